// File: inc/peus_params.svh
`ifndef PEUS_PARAMS_SVH
`define PEUS_PARAMS_SVH

// Register byte offsets
`define PEUS_ADR_W        8
`define PEUS_OFS_CMD      8'h00
`define PEUS_OFS_PIN_IN   8'h04
`define PEUS_OFS_UNBLK_IN 8'h08
`define PEUS_OFS_NEW_PIN  8'h0C
`define PEUS_OFS_SW       8'h10
`define PEUS_OFS_STATE    8'h14
`define PEUS_OFS_TEMPLATE 8'h18

// Command register fields
`define PEUS_CMD_INS_LSB  0
`define PEUS_CMD_P2_LSB   8
`define PEUS_CMD_EMPTY    16

// Instruction codes
`define PEUS_INS_VERIFY   8'h20
`define PEUS_INS_ENABLE   8'h28
`define PEUS_INS_UNBLOCK  8'h2C
`define PEUS_INS_READ     8'hB0
`define PEUS_INS_STATUS   8'hF2
`define PEUS_INS_CARD_RST 8'hFF
`define PEUS_PIN_REF      8'h01

// Status words
`define PEUS_SW_OK        16'h9000
`define PEUS_SW_RETRY_HI  12'h63C
`define PEUS_SW_DENIED    16'h6982
`define PEUS_SW_BLOCKED   16'h6983
`define PEUS_SW_NOT_ALLOW 16'h6985
`define PEUS_SW_BAD_REF   16'h6A88
`define PEUS_SW_BAD_INS   16'h6D00

// Pin status template
`define PEUS_TPL_TAG      8'h90
`define PEUS_TPL_LEN      8'h01
`define PEUS_TPL_ENABLED  8'h80
`define PEUS_TPL_DISABLED 8'h00

// Reset values
`define PEUS_PIN_TRIES    2'h3
`define PEUS_UNBLK_TRIES  4'hA
`define PEUS_PIN_INIT     32'h3030_3030
`define PEUS_UNBLK_INIT   32'h1234_5678

`endif

// File: inc/peus_pkg.sv
package peus_pkg;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } peus_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } peus_wb_rsp_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic [16:0] cmd;
    logic [31:0] pin_in;
    logic [31:0] unblk_in;
    logic [31:0] new_pin;
    logic [31:0] pin_val;
    logic [31:0] unblk_val;
    logic [1:0]  pin_cnt;
    logic [3:0]  unblk_cnt;
    logic        enabled;
    logic        verified;
    logic [15:0] sw;
  } peus_state_t;

endpackage

// File: verilog/peus_core.sv
`timescale 1ns/1ps
`include "peus_params.svh"
module peus_core #(
  parameter logic [31:0] PIN_INIT    = `PEUS_PIN_INIT,
  parameter logic [31:0] UNBLK_INIT  = `PEUS_UNBLK_INIT,
  parameter logic        PIN_EN_INIT = 1'b1
) (
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_rst,
  input  wire peus_pkg::peus_wb_req_t i_wb,
  output peus_pkg::peus_wb_rsp_t      o_wb
);

  peus_pkg::peus_state_t s_r;
  peus_pkg::peus_state_t s_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] retry_sw(input logic [3:0] cnt);
    return {`PEUS_SW_RETRY_HI, cnt};
  endfunction

  // Command word fields
  function automatic logic [7:0] cmd_ins(input logic [16:0] w);
    return w[`PEUS_CMD_INS_LSB +: 8];
  endfunction

  function automatic logic [7:0] cmd_p2(input logic [16:0] w);
    return w[`PEUS_CMD_P2_LSB +: 8];
  endfunction

  function automatic logic cmd_empty(input logic [16:0] w);
    return w[`PEUS_CMD_EMPTY];
  endfunction

  // Commands that carry a PIN reference in P2
  function automatic logic names_pin(input logic [7:0] code);
    return (code == `PEUS_INS_VERIFY) || (code == `PEUS_INS_ENABLE) ||
           (code == `PEUS_INS_UNBLOCK);
  endfunction

  function automatic logic [15:0] pin_retry_sw(input logic [1:0] cnt);
    return retry_sw({2'b00, cnt});
  endfunction

  // One try used; an empty counter stays empty
  function automatic logic [1:0] pin_step(input logic [1:0] cnt);
    logic [1:0] r;
    r = 2'h0;
    if (cnt != 2'h0)
    begin
      r = 2'(cnt - 2'h1);
    end
    return r;
  endfunction

  function automatic logic [3:0] unblk_step(input logic [3:0] cnt);
    logic [3:0] r;
    r = 4'h0;
    if (cnt != 4'h0)
    begin
      r = 4'(cnt - 4'h1);
    end
    return r;
  endfunction

  // Whole-word compare, no early exit on the first differing byte
  function automatic logic same_code(input logic [31:0] a,
                                     input logic [31:0] b);
    return (a ^ b) == 32'h0000_0000;
  endfunction

  // Protected read refused while the PIN guards it and is not satisfied
  function automatic logic read_denied(input logic en,
                                       input logic ver,
                                       input logic blk);
    logic r;
    r = 1'b0;
    if (en)
    begin
      r = ~ver | blk;
    end
    return r;
  endfunction

  function automatic logic [31:0] state_word(input peus_pkg::peus_state_t s,
                                             input logic                  pb,
                                             input logic                  ub);
    logic [31:0] r;
    r        = 32'h0000_0000;
    r[0]     = s.enabled;
    r[1]     = s.verified;
    r[2]     = pb;
    r[3]     = ub;
    r[9:8]   = s.pin_cnt;
    r[15:12] = s.unblk_cnt;
    return r;
  endfunction

  // Template: tag, length, then the enabled flag byte
  function automatic logic [31:0] tpl_word(input logic en);
    logic [7:0] v;
    v = en ? `PEUS_TPL_ENABLED : `PEUS_TPL_DISABLED;
    return {8'h00, `PEUS_TPL_TAG, `PEUS_TPL_LEN, v};
  endfunction

  // Provisioned store at power-up; a card reset never returns here
  localparam peus_pkg::peus_state_t RST_STATE = '{
    pin_val:   PIN_INIT,
    unblk_val: UNBLK_INIT,
    pin_cnt:   `PEUS_PIN_TRIES,
    unblk_cnt: `PEUS_UNBLK_TRIES,
    enabled:   PIN_EN_INIT,
    sw:        `PEUS_SW_OK,
    default:   '0
  };

  logic        hit;
  logic [7:0]  ins;
  logic [7:0]  p2;
  logic        empty;
  logic        pin_blk;
  logic        unblk_blk;
  logic [1:0]  pin_dec;
  logic [3:0]  unblk_dec;
  logic [16:0] cmd_w;
  logic [31:0] cmd_m;
  logic        pin_ok;
  logic        unblk_ok;

  always_comb
  begin
    s_nxt     = s_r;
    s_nxt.ack = 1'b0;
    hit       = i_wb.cyc & i_wb.stb & ~s_r.ack;
    cmd_m     = merge({15'h0000, s_r.cmd}, i_wb.dat, i_wb.sel);
    cmd_w     = cmd_m[16:0];
    ins       = cmd_ins(cmd_w);
    p2        = cmd_p2(cmd_w);
    empty     = cmd_empty(cmd_w);
    pin_blk   = (s_r.pin_cnt == 2'h0);
    unblk_blk = (s_r.unblk_cnt == 4'h0);
    pin_dec   = pin_step(s_r.pin_cnt);
    unblk_dec = unblk_step(s_r.unblk_cnt);
    pin_ok    = same_code(s_r.pin_in, s_r.pin_val);
    unblk_ok  = same_code(s_r.unblk_in, s_r.unblk_val);
    if (hit)
    begin
      s_nxt.ack  = 1'b1;
      s_nxt.rdat = 32'h0000_0000;
      if (i_wb.we)
      begin
        unique case (i_wb.adr)
          `PEUS_OFS_PIN_IN:
          begin
            s_nxt.pin_in = merge(s_r.pin_in, i_wb.dat, i_wb.sel);
          end
          `PEUS_OFS_UNBLK_IN:
          begin
            s_nxt.unblk_in = merge(s_r.unblk_in, i_wb.dat, i_wb.sel);
          end
          `PEUS_OFS_NEW_PIN:
          begin
            s_nxt.new_pin = merge(s_r.new_pin, i_wb.dat, i_wb.sel);
          end
          `PEUS_OFS_CMD:
          begin
            s_nxt.cmd = cmd_w;
            // Any write to the command word runs the command
            if (names_pin(ins) && p2 != `PEUS_PIN_REF)
            begin
              s_nxt.sw = `PEUS_SW_BAD_REF;
            end
            else
            begin
              unique case (ins)
                `PEUS_INS_VERIFY:
                begin
                  if (empty)
                  begin
                    s_nxt.sw = pin_retry_sw(s_r.pin_cnt);
                  end
                  else if (pin_blk)
                  begin
                    s_nxt.sw = `PEUS_SW_BLOCKED;
                  end
                  else if (pin_ok)
                  begin
                    s_nxt.pin_cnt  = `PEUS_PIN_TRIES;
                    s_nxt.verified = 1'b1;
                    s_nxt.sw       = `PEUS_SW_OK;
                  end
                  else
                  begin
                    s_nxt.pin_cnt  = pin_dec;
                    if (pin_dec == 2'h0)
                    begin
                      // Blocking ends the verified session
                      s_nxt.verified = 1'b0;
                    end
                    s_nxt.sw       = pin_retry_sw(pin_dec);
                  end
                end
                `PEUS_INS_ENABLE:
                begin
                  if (pin_blk)
                  begin
                    s_nxt.sw = `PEUS_SW_BLOCKED;
                  end
                  else if (s_r.enabled)
                  begin
                    s_nxt.sw = `PEUS_SW_NOT_ALLOW;
                  end
                  else if (empty)
                  begin
                    s_nxt.sw = pin_retry_sw(s_r.pin_cnt);
                  end
                  else if (pin_ok)
                  begin
                    s_nxt.pin_cnt  = `PEUS_PIN_TRIES;
                    s_nxt.enabled  = 1'b1;
                    s_nxt.verified = 1'b1;
                    s_nxt.sw       = `PEUS_SW_OK;
                  end
                  else
                  begin
                    s_nxt.pin_cnt = pin_dec;
                    s_nxt.sw      = pin_retry_sw(pin_dec);
                  end
                end
                `PEUS_INS_UNBLOCK:
                begin
                  if (empty)
                  begin
                    // Counter reported even for a blocked PIN
                    if (unblk_blk)
                    begin
                      s_nxt.sw = `PEUS_SW_BLOCKED;
                    end
                    else
                    begin
                      s_nxt.sw = retry_sw(s_r.unblk_cnt);
                    end
                  end
                  else if (unblk_blk)
                  begin
                    s_nxt.sw = `PEUS_SW_BLOCKED;
                  end
                  else if (unblk_ok)
                  begin
                    // Counters and new value load on the same edge; PIN state ignored
                    s_nxt.pin_cnt   = `PEUS_PIN_TRIES;
                    s_nxt.pin_val   = s_r.new_pin;
                    s_nxt.unblk_cnt = `PEUS_UNBLK_TRIES;
                    s_nxt.enabled   = 1'b1;
                    s_nxt.verified  = 1'b1;
                    s_nxt.sw        = `PEUS_SW_OK;
                  end
                  else
                  begin
                    // Only the shared unblock counter moves
                    s_nxt.unblk_cnt = unblk_dec;
                    s_nxt.sw        = retry_sw(unblk_dec);
                  end
                end
                `PEUS_INS_READ:
                begin
                  s_nxt.sw = read_denied(s_r.enabled, s_r.verified, pin_blk)
                           ? `PEUS_SW_DENIED : `PEUS_SW_OK;
                end
                `PEUS_INS_STATUS:
                begin
                  s_nxt.sw = `PEUS_SW_OK;
                end
                `PEUS_INS_CARD_RST:
                begin
                  // Session ends; stored state untouched
                  s_nxt.verified = 1'b0;
                  s_nxt.sw       = `PEUS_SW_OK;
                end
                default:
                begin
                  s_nxt.sw = `PEUS_SW_BAD_INS;
                end
              endcase
            end
          end
          default:
          begin
            // Writes to read-only or unmapped words are dropped
          end
        endcase
      end
      else
      begin
        unique case (i_wb.adr)
          `PEUS_OFS_CMD:
          begin
            s_nxt.rdat = {15'h0000, s_r.cmd};
          end
          `PEUS_OFS_SW:
          begin
            s_nxt.rdat = {16'h0000, s_r.sw};
          end
          `PEUS_OFS_STATE:
          begin
            s_nxt.rdat = state_word(s_r, pin_blk, unblk_blk);
          end
          `PEUS_OFS_TEMPLATE:
          begin
            s_nxt.rdat = tpl_word(s_r.enabled);
          end
          default:
          begin
            s_nxt.rdat = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      s_r <= RST_STATE;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign o_wb.ack = s_r.ack;
  assign o_wb.dat = s_r.rdat;

endmodule // peus_core

// File: sim/peus_sva.sv
`timescale 1ns/1ps
module peus_sva (
  input wire logic                   i_ref_clk,
  input wire logic                   i_rst,
  input wire peus_pkg::peus_wb_req_t i_wb,
  input wire peus_pkg::peus_wb_rsp_t o_wb
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  wire rd = o_wb.ack && !i_wb.we;
  sequence taken_s;
    i_wb.cyc && i_wb.stb && !o_wb.ack;
  endsequence
  sequence pulse_s;
    o_wb.ack ##1 !o_wb.ack;
  endsequence
  chk_ack_follows: assert property (taken_s |=> pulse_s)
    else $error("ack not one cycle after request");
  chk_ack_cause: assert property ($rose(o_wb.ack) |-> $past(i_wb.cyc && i_wb.stb))
    else $error("ack without request");
  chk_wr_zero: assert property (o_wb.ack && i_wb.we |-> o_wb.dat == 32'h0)
    else $error("write answer carries data");
  chk_dat_hold: assert property (!o_wb.ack |-> $stable(o_wb.dat))
    else $error("read data moved between answers");
  chk_tpl_form: assert property (rd && i_wb.adr == 8'h18 |->
    o_wb.dat[31:8] == 24'h009001 && o_wb.dat[7:0] inside {8'h80, 8'h00})
    else $error("template malformed");
  chk_pin_block: assert property (rd && i_wb.adr == 8'h14 |->
    o_wb.dat[2] == (o_wb.dat[9:8] == 2'h0))
    else $error("pin blocked flag disagrees with count");
  chk_unblk_block: assert property (rd && i_wb.adr == 8'h14 |->
    o_wb.dat[3] == (o_wb.dat[15:12] == 4'h0) && o_wb.dat[15:12] <= 4'hA)
    else $error("unblock flag disagrees with count");
  chk_retry_range: assert property (rd && i_wb.adr == 8'h10 && o_wb.dat[15:4] == 12'h63C
    |-> o_wb.dat[3:0] <= 4'hA)
    else $error("retry count out of range");
endmodule // peus_sva
bind peus_core peus_sva i_peus_sva (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wb(i_wb),
  .o_wb(o_wb));

// File: sim/peus_term.sv
`timescale 1ns/1ps
module peus_term (
  input  wire logic                   i_ref_clk,
  input  wire peus_pkg::peus_wb_rsp_t i_rsp,
  output peus_pkg::peus_wb_req_t      o_req
);
  initial o_req = '0;
  // Holds the request until ack is sampled, then releases
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge i_ref_clk);
    o_req <= '{1'b1, 1'b1, w, a, 4'hF, d};
    do @(posedge i_ref_clk); while (i_rsp.ack !== 1'b1);
    q = i_rsp.dat;
    o_req <= '0;
  endtask
endmodule // peus_term

// File: sim/tb_peus_core.sv
`timescale 1ns/1ps
module tb_peus_core;
  localparam logic [31:0] P0 = 32'h1111_2222;
  localparam logic [31:0] U0 = 32'h5A5A_0F0F;
  logic                   clk = 1'b0;
  logic                   rst = 1'b1;
  peus_pkg::peus_wb_req_t req;
  peus_pkg::peus_wb_rsp_t rsp;
  logic [31:0]            eq[$];
  logic [31:0]            mq[$];
  logic [31:0]            q;
  logic [31:0]            pin;
  logic [31:0]            seed = 32'h7d4c;
  int                     miscompares = 0;
  int                     n_compared = 0;
  int                     cyc_n = 0;
  int                     i;
  peus_core #(.PIN_INIT(P0), .UNBLK_INIT(U0), .PIN_EN_INIT(1'b0)) i_peus_core (
    .i_ref_clk(clk), .i_rst(rst), .i_wb(req), .o_wb(rsp));
  peus_term i_peus_term (.i_ref_clk(clk), .i_rsp(rsp), .o_req(req));
  initial forever #5 clk = ~clk;
  task end_sim;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000)
    begin
      miscompares++;
      end_sim();
    end
    if (rsp.ack === 1'b1 && req.we === 1'b0 && eq.size() > 0)
    begin
      n_compared++;
      if ((rsp.dat & mq[0]) !== (eq[0] & mq[0]))
      begin
        miscompares++;
        $display("unexpected at %0t: got %h want %h", $time, rsp.dat, eq[0]);
      end
      void'(eq.pop_front());
      void'(mq.pop_front());
    end
  end
  function automatic logic [31:0] bad(input logic [31:0] v);
    return v ^ ($random(seed) | 32'h1);
  endfunction
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    eq.push_back(e);
    mq.push_back(m);
    i_peus_term.xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_peus_term.xfer(1'b1, a, d, q);
  endtask
  task automatic cmd(input logic [7:0] ins, input logic e, input logic [15:0] sw);
    wr(8'h00, {15'h0, e, 8'h01, ins});
    rd(8'h10, {16'h0, sw}, 32'h0000_FFFF);
  endtask
  task automatic pres(input logic [7:0] ins, input logic [31:0] p, input logic [15:0] sw);
    wr(8'h04, p);
    cmd(ins, 1'b0, sw);
  endtask
  task automatic unb(input logic [31:0] u, input logic [31:0] n, input logic [15:0] sw);
    wr(8'h08, u);
    wr(8'h0C, n);
    cmd(8'h2C, 1'b0, sw);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cmd(8'hB0, 1'b0, 16'h9000);
    pres(8'h28, bad(P0), 16'h63C2);
    cmd(8'hB0, 1'b0, 16'h9000);
    rd(8'h18, 32'h0090_0100, '1);
    pres(8'h28, bad(P0), 16'h63C1);
    pres(8'h28, P0, 16'h9000);
    rd(8'h18, 32'h0090_0180, '1);
    cmd(8'h20, 1'b1, 16'h63C3);
    pres(8'h28, P0, 16'h6985);
    $display("done: enable");
    wr(8'h00, 32'h0000_00FF);
    cmd(8'hB0, 1'b0, 16'h6982);
    pres(8'h20, P0, 16'h9000);
    cmd(8'hB0, 1'b0, 16'h9000);
    for (i = 2; i >= 0; i--) pres(8'h20, bad(P0), {12'h63C, i[3:0]});
    wr(8'h00, 32'h0000_00FF);
    pres(8'h20, P0, 16'h6983);
    cmd(8'hB0, 1'b0, 16'h6982);
    rd(8'h14, 32'h0000_A005, 32'h0000_F30F);
    cmd(8'h2C, 1'b1, 16'h63CA);
    $display("done: pin block");
    for (i = 9; i >= 1; i--)
    begin
      if (i == 5) wr(8'h00, 32'h0000_00FF);
      unb(bad(U0), 32'h0, {12'h63C, i[3:0]});
    end
    cmd(8'h20, 1'b1, 16'h63C0);
    cmd(8'h2C, 1'b1, 16'h63C1);
    pin = $random(seed);
    unb(U0, pin, 16'h9000);
    cmd(8'h20, 1'b1, 16'h63C3);
    cmd(8'h2C, 1'b1, 16'h63CA);
    cmd(8'hB0, 1'b0, 16'h9000);
    pres(8'h20, pin, 16'h9000);
    $display("done: unblock");
    for (i = 9; i >= 0; i--) unb(bad(U0), pin, {12'h63C, i[3:0]});
    unb(U0, P0, 16'h6983);
    cmd(8'h2C, 1'b1, 16'h6983);
    pres(8'h20, pin, 16'h9000);
    wr(8'h00, 32'h0000_0220);
    rd(8'h10, 32'h0000_6A88, 32'h0000_FFFF);
    wr(8'h00, 32'h0000_0133);
    rd(8'h10, 32'h0000_6D00, 32'h0000_FFFF);
    rd(8'h40, 32'h0, '1);
    $display("done: unblock lock");
    end_sim();
  end
endmodule // tb_peus_core
